/* design/assc_pkg.sv */
package assc_pkg;

  // clock rate
  localparam int unsigned CLK_HZ = 125_000_000;

  // sampling periods and switch off times, in microseconds
  localparam int unsigned MAIN_RISE_PERIOD_US = 31_250;
  localparam int unsigned BATT_PERIOD_US      = 3_000_000;
  localparam int unsigned CHARGE_PERIOD_US    = 1_500_000;
  localparam int unsigned OFF_2MS_US          = 2_000;
  localparam int unsigned OFF_128MS_US        = 128_000;
  localparam int unsigned OFF_256MS_US        = 256_000;
  localparam int unsigned CYC_PER_US          = CLK_HZ / 1_000_000;

  // derived cycle counts (rounded down, sampling periods and switch off times)
  localparam int unsigned MAIN_RISE_CYC  = MAIN_RISE_PERIOD_US * CYC_PER_US;
  localparam int unsigned BATT_CYC       = BATT_PERIOD_US * CYC_PER_US;
  localparam int unsigned CHARGE_CYC     = CHARGE_PERIOD_US * CYC_PER_US;
  localparam int unsigned OFF_2MS_CYC    = OFF_2MS_US * CYC_PER_US;
  localparam int unsigned OFF_128MS_CYC  = OFF_128MS_US * CYC_PER_US;
  localparam int unsigned OFF_256MS_CYC  = OFF_256MS_US * CYC_PER_US;

  // register byte addresses
  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;

  // config field positions
  localparam int CFG_SEL_LSB     = 0;
  localparam int CFG_AUTO_BIT    = 2;
  localparam int CFG_CHG_BIT     = 3;
  localparam int CFG_LDET_BIT    = 4;
  localparam int CFG_LDETBK_BIT  = 5;
  localparam int CFG_OFF_LSB     = 6;

  // status field positions
  localparam int ST_LOW_FLAG_BIT = 0;
  localparam int ST_BACKUP_BIT   = 1;
  localparam int ST_CHARGE_BIT   = 2;
  localparam int ST_SW_LSB       = 3;

  // select and off time codes (SEL_RESET and OFF_NONE after reset)
  localparam logic [1:0] SEL_RESET   = 2'h1;
  localparam logic [1:0] SEL_MAIN    = 2'h2;
  localparam logic [1:0] OFF_NONE    = 2'h0;
  localparam logic [1:0] OFF_2MS     = 2'h1;
  localparam logic [1:0] OFF_128MS   = 2'h2;
  localparam logic [1:0] OFF_256MS   = 2'h3;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // operating modes
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_CHARGING,
    MODE_BACKUP
  } assc_mode_type;

endpackage

/* design/assc_top.sv */
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
// What this block does
// - power-on: isolation off, charge a off, b on
// - reset clears auto and charge, select 01
// - manual select 10 gives main-only switches
// - auto off: no detection, switching or charging
// - normal auto: drop enters backup mode
// - backup: sample rise every 31.25 ms
// - battery low sampled every 3 s
// - battery low sets flag only
// - charge compare twice per 3 s, all on
// - battery above main ends charging
// - drop detection works while charging too
// - backup suspends charge control
// - isolation switch opens during drop detection
// - off time code: none, 2, 128, 256 ms
// - no drop at point: stay on till next
// - auto mode ignores switch select
// - flag after two low samples, write-zero clear
// - backup disables host interface
module assc_top
  import assc_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // axi4-lite write address
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // comparator inputs (asynchronous)
  input  wire logic        main_drop_cmp,
  input  wire logic        main_rise_cmp,
  input  wire logic        batt_drop_cmp,
  input  wire logic        batt_below_main_cmp,
  // power switches and status
  output logic             main_isolation_switch,
  output logic             charge_switch_a,
  output logic             charge_switch_b,
  output logic             backup_low_flag,
  output logic             host_if_enable
);

  ////////////////////////////////////////////////////////////////////////////
  // comparator synchronisers

  logic [3:0] cmp_meta_reg;
  logic [3:0] cmp_sync_reg;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cmp_meta_reg <= 4'h0;
      cmp_sync_reg <= 4'h0;
    end else begin
      cmp_meta_reg <= {batt_below_main_cmp, batt_drop_cmp, main_rise_cmp, main_drop_cmp};
      cmp_sync_reg <= cmp_meta_reg;
    end
  end

  logic main_drop;
  logic main_rise;
  logic batt_drop;
  logic batt_below;
  assign main_drop  = cmp_sync_reg[0];
  assign main_rise  = cmp_sync_reg[1];
  assign batt_drop  = cmp_sync_reg[2];
  assign batt_below = cmp_sync_reg[3];

  ////////////////////////////////////////////////////////////////////////////
  // configuration and bus state

  logic [1:0]    sel_reg, sel_next;
  logic          auto_reg, auto_next;
  logic          chg_reg, chg_next;
  logic          ldet_reg, ldet_next;
  logic          ldetbk_reg, ldetbk_next;
  logic [1:0]    off_reg, off_next;
  logic          flag_reg, flag_next;
  logic          awready_reg, awready_next;
  logic          wready_reg, wready_next;
  logic          bvalid_reg, bvalid_next;
  logic [1:0]    bresp_reg, bresp_next;
  logic          arready_reg, arready_next;
  logic          rvalid_reg, rvalid_next;
  logic [1:0]    rresp_reg, rresp_next;
  logic [31:0]   rdata_reg, rdata_next;
  logic [3:0]    awaddr_reg, awaddr_next;
  logic          aw_have_reg, aw_have_next;
  logic [31:0]   wdata_reg, wdata_next;
  logic [3:0]    wstrb_reg, wstrb_next;
  logic          w_have_reg, w_have_next;

  assc_mode_type mode_reg, mode_next;
  logic          sw1_reg, sw1_next;
  logic          sw2_reg, sw2_next;
  logic          sw3_reg, sw3_next;
  logic          host_if_reg, host_if_next;
  logic [31:0]   main_cnt_reg, main_cnt_next;
  logic [31:0]   batt_cnt_reg, batt_cnt_next;
  logic [31:0]   chg_cnt_reg, chg_cnt_next;
  logic [31:0]   off_cnt_reg, off_cnt_next;
  logic          low_seen_reg, low_seen_next;
  logic          flag_set;

  logic          in_backup;
  assign in_backup = (mode_reg == MODE_BACKUP);

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave and register next values

  always_comb begin
    sel_next     = sel_reg;
    auto_next    = auto_reg;
    chg_next     = chg_reg;
    ldet_next    = ldet_reg;
    ldetbk_next  = ldetbk_reg;
    off_next     = off_reg;
    flag_next    = flag_reg;
    awready_next = 1'b0;
    wready_next  = 1'b0;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    arready_next = 1'b0;
    rvalid_next  = rvalid_reg;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    awaddr_next  = awaddr_reg;
    aw_have_next = aw_have_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    w_have_next  = w_have_reg;
    // capture address and data in either order
    if (s_axi_awvalid && !aw_have_reg && !awready_reg && !in_backup) begin
      awready_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
      aw_have_next = 1'b1;
    end
    if (s_axi_wvalid && !w_have_reg && !wready_reg && !in_backup) begin
      wready_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
      w_have_next = 1'b1;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    // perform write once both halves held
    if (aw_have_reg && w_have_reg && !bvalid_reg) begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = RESP_OKAY;
      if (awaddr_reg == ADDR_CONFIG) begin
        if (wstrb_reg[0]) begin
          sel_next    = wdata_reg[CFG_SEL_LSB +: 2];
          auto_next   = wdata_reg[CFG_AUTO_BIT];
          chg_next    = wdata_reg[CFG_CHG_BIT];
          ldet_next   = wdata_reg[CFG_LDET_BIT];
          ldetbk_next = wdata_reg[CFG_LDETBK_BIT];
          off_next    = wdata_reg[CFG_OFF_LSB +: 2];
        end
      end else if (awaddr_reg == ADDR_STATUS) begin
        if (wstrb_reg[0] && !wdata_reg[ST_LOW_FLAG_BIT]) begin
          flag_next = 1'b0;
        end
      end else begin
        bresp_next = RESP_SLVERR;
      end
    end
    // hardware set wins over software clear
    if (flag_set) begin
      flag_next = 1'b1;
    end
    // read channel
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && !arready_reg && !rvalid_reg && !in_backup) begin
      arready_next = 1'b1;
      rvalid_next  = 1'b1;
      rresp_next   = RESP_OKAY;
      rdata_next   = 32'h0;
      if (s_axi_araddr == ADDR_CONFIG) begin
        rdata_next[CFG_SEL_LSB +: 2] = sel_reg;
        rdata_next[CFG_AUTO_BIT]     = auto_reg;
        rdata_next[CFG_CHG_BIT]      = chg_reg;
        rdata_next[CFG_LDET_BIT]     = ldet_reg;
        rdata_next[CFG_LDETBK_BIT]   = ldetbk_reg;
        rdata_next[CFG_OFF_LSB +: 2] = off_reg;
      end else if (s_axi_araddr == ADDR_STATUS) begin
        rdata_next[ST_LOW_FLAG_BIT] = flag_reg;
        rdata_next[ST_BACKUP_BIT]   = in_backup;
        rdata_next[ST_CHARGE_BIT]   = (mode_reg == MODE_CHARGING);
        rdata_next[ST_SW_LSB +: 3]  = {sw3_reg, sw2_reg, sw1_reg};
      end else begin
        rresp_next = RESP_SLVERR;
      end
    end
  end

  // configuration reset values
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sel_reg     <= SEL_RESET;
      auto_reg    <= 1'b0;
      chg_reg     <= 1'b0;
      ldet_reg    <= 1'b0;
      ldetbk_reg  <= 1'b0;
      off_reg     <= OFF_NONE;
      flag_reg    <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= 32'h0;
      awaddr_reg  <= 4'h0;
      aw_have_reg <= 1'b0;
      wdata_reg   <= 32'h0;
      wstrb_reg   <= 4'h0;
      w_have_reg  <= 1'b0;
    end else begin
      sel_reg     <= sel_next;
      auto_reg    <= auto_next;
      chg_reg     <= chg_next;
      ldet_reg    <= ldet_next;
      ldetbk_reg  <= ldetbk_next;
      off_reg     <= off_next;
      flag_reg    <= flag_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
      awaddr_reg  <= awaddr_next;
      aw_have_reg <= aw_have_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      w_have_reg  <= w_have_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // auto switching state machine and schedules

  logic [31:0] off_len;
  always_comb begin
    unique case (off_reg)
      OFF_NONE:  off_len = 32'h0;
      OFF_2MS:   off_len = 32'(OFF_2MS_CYC);
      OFF_128MS: off_len = 32'(OFF_128MS_CYC);
      OFF_256MS: off_len = 32'(OFF_256MS_CYC);
    endcase
  end

  always_comb begin
    logic main_tick;
    logic batt_tick;
    logic chg_tick;
    logic det_window;
    main_tick     = (main_cnt_reg == 32'(MAIN_RISE_CYC) - 32'h1);
    batt_tick     = (batt_cnt_reg == 32'(BATT_CYC) - 32'h1);
    chg_tick      = (chg_cnt_reg == 32'(CHARGE_CYC) - 32'h1);
    mode_next     = mode_reg;
    sw1_next      = sw1_reg;
    sw2_next      = sw2_reg;
    sw3_next      = sw3_reg;
    off_cnt_next  = off_cnt_reg;
    low_seen_next = low_seen_reg;
    flag_set      = 1'b0;
    main_cnt_next = main_tick ? 32'h0 : main_cnt_reg + 32'h1;
    batt_cnt_next = batt_tick ? 32'h0 : batt_cnt_reg + 32'h1;
    chg_cnt_next  = chg_tick ? 32'h0 : chg_cnt_reg + 32'h1;
    // drop seen only in the isolated window when an off time is chosen
    det_window    = (off_reg == OFF_NONE) || (off_cnt_reg != 32'h0);
    if (!auto_reg) begin
      // manual switch control, monitors stopped
      mode_next     = MODE_NORMAL;
      main_cnt_next = 32'h0;
      batt_cnt_next = 32'h0;
      chg_cnt_next  = 32'h0;
      off_cnt_next  = 32'h0;
      low_seen_next = 1'b0;
      if (sel_reg == SEL_MAIN) begin
        sw1_next = 1'b1;
        sw2_next = 1'b0;
        sw3_next = 1'b0;
      end else begin
        sw1_next = 1'b0;
        sw2_next = 1'b0;
        sw3_next = 1'b1;
      end
    end else begin
      // battery low check, normal or enabled in backup
      if (batt_tick && ldet_reg && (!in_backup || ldetbk_reg)) begin
        low_seen_next = batt_drop;
        flag_set      = batt_drop && low_seen_reg;
      end
      unique case (mode_reg)
        MODE_NORMAL, MODE_CHARGING: begin
          // auto logic owns every switch, select ignored
          sw1_next = 1'b1;
          sw2_next = (mode_reg == MODE_CHARGING);
          sw3_next = (mode_reg == MODE_CHARGING);
          // isolation pulse at each main sampling point
          if (main_tick && (off_reg != OFF_NONE)) begin
            off_cnt_next = off_len;
          end else if (off_cnt_reg != 32'h0) begin
            off_cnt_next = off_cnt_reg - 32'h1;
          end
          if (off_cnt_reg != 32'h0) begin
            sw1_next = 1'b0;
          end
          if (chg_reg && chg_tick) begin
            if (batt_below) begin
              mode_next = MODE_CHARGING;
            end else begin
              mode_next = MODE_NORMAL;
            end
          end
          if (main_drop && det_window) begin
            mode_next     = MODE_BACKUP;
            sw1_next      = 1'b0;
            sw2_next      = 1'b0;
            sw3_next      = 1'b1;
            off_cnt_next  = 32'h0;
            main_cnt_next = 32'h0;
            batt_cnt_next = 32'h0;
            chg_cnt_next  = 32'h0;
          end
        end
        MODE_BACKUP: begin
          // battery powers core, no charge control
          sw1_next     = 1'b0;
          sw2_next     = 1'b0;
          sw3_next     = 1'b1;
          chg_cnt_next = 32'h0;
          if (main_tick && main_rise) begin
            mode_next     = MODE_NORMAL;
            sw1_next      = 1'b1;
            sw3_next      = 1'b0;
            main_cnt_next = 32'h0;
            batt_cnt_next = 32'h0;
          end
        end
      endcase
    end
    // host side follows the mode being entered
    host_if_next = (mode_next != MODE_BACKUP);
  end

  // switch state and counters
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mode_reg     <= MODE_NORMAL;
      sw1_reg      <= 1'b0;
      sw2_reg      <= 1'b0;
      sw3_reg      <= 1'b1;
      main_cnt_reg <= 32'h0;
      batt_cnt_reg <= 32'h0;
      chg_cnt_reg  <= 32'h0;
      off_cnt_reg  <= 32'h0;
      low_seen_reg <= 1'b0;
      host_if_reg  <= 1'b1;
    end else begin
      mode_reg     <= mode_next;
      sw1_reg      <= sw1_next;
      sw2_reg      <= sw2_next;
      sw3_reg      <= sw3_next;
      main_cnt_reg <= main_cnt_next;
      batt_cnt_reg <= batt_cnt_next;
      chg_cnt_reg  <= chg_cnt_next;
      off_cnt_reg  <= off_cnt_next;
      low_seen_reg <= low_seen_next;
      host_if_reg  <= host_if_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign main_isolation_switch = sw1_reg;
  assign charge_switch_a       = sw2_reg;
  assign charge_switch_b       = sw3_reg;
  assign backup_low_flag       = flag_reg;
  assign host_if_enable        = host_if_reg;
  assign s_axi_awready         = awready_reg;
  assign s_axi_wready          = wready_reg;
  assign s_axi_bvalid          = bvalid_reg;
  assign s_axi_bresp           = bresp_reg;
  assign s_axi_arready         = arready_reg;
  assign s_axi_rvalid          = rvalid_reg;
  assign s_axi_rresp           = rresp_reg;
  assign s_axi_rdata           = rdata_reg;

endmodule

/* tb/assc_top_monitor.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module assc_top_monitor
  import assc_pkg::*;
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        nrst,
  // bus handshakes
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // supply side
  input wire logic        main_drop_cmp,
  input wire logic        main_isolation_switch,
  input wire logic        charge_switch_a,
  input wire logic        charge_switch_b,
  input wire logic        backup_low_flag,
  input wire logic        host_if_enable
);
  logic [5:0] drop_hist_reg;
  logic [5:0] drop_hist_next;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // recent history of the drop comparator
  always_comb begin
    drop_hist_next = {drop_hist_reg[4:0], main_drop_cmp};
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      drop_hist_reg <= 6'h00;
    end else begin
      drop_hist_reg <= drop_hist_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_reset_state: assert property ($rose(nrst) |-> !main_isolation_switch
    && !charge_switch_a && charge_switch_b && !backup_low_flag && host_if_enable)
    else $error("switch state after reset wrong");
  a_backup_switches: assert property (!host_if_enable |->
    !main_isolation_switch && !charge_switch_a && charge_switch_b)
    else $error("switches wrong in backup");
  a_backup_cause: assert property ($fell(host_if_enable) |-> drop_hist_reg != 6'h00)
    else $error("backup entered without a drop");
  a_backup_refused: assert property (!host_if_enable && !$past(host_if_enable) |->
    !s_axi_awready && !s_axi_wready && !s_axi_arready)
    else $error("bus request taken in backup");
  a_write_answer: assert property (s_axi_awready && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arready |-> s_axi_rvalid)
    else $error("read data not with arready");
  a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answered twice");
  a_charge_pair: assert property (charge_switch_a == charge_switch_b ||
    (!main_isolation_switch && !charge_switch_a && charge_switch_b))
    else $error("charge switches split");

  // main scenarios
  c_backup: cover property ($fell(host_if_enable));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  c_main_only: cover property (main_isolation_switch && !charge_switch_b);
endmodule

bind assc_top assc_top_monitor i_assc_top_monitor (.mclk, .nrst, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bresp, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .main_drop_cmp, .main_isolation_switch, .charge_switch_a,
  .charge_switch_b, .backup_low_flag, .host_if_enable);

/* tb/assc_top_tb.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin bad_count++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end

module assc_top_tb;
  import assc_pkg::*;
  logic        mclk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, main_drop_cmp, main_rise_cmp;
  logic        batt_drop_cmp, batt_below_main_cmp, main_isolation_switch;
  logic        charge_switch_a, charge_switch_b, backup_low_flag, host_if_enable;
  logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          bad_count = 0;
  int          samples_checked = 0;
  logic        seen;

  assc_top i_assc_top (.mclk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .main_drop_cmp, .main_rise_cmp,
    .batt_drop_cmp, .batt_below_main_cmp, .main_isolation_switch, .charge_switch_a,
    .charge_switch_b, .backup_low_flag, .host_if_enable);

  // clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // write, wait for the response, compare it
  task automatic wr_chk(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er,
                        input string nm);
    logic got_aw, got_w;
    got_aw = 1'b0;
    got_w = 1'b0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!s_axi_bvalid) begin
      @(posedge mclk);
      if (s_axi_awready) begin
        got_aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready) begin
        got_w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b0;
    `CHK(nm, {1'b1, 1'b1, er}, {got_aw, got_w, s_axi_bresp})
  endtask

  // read, wait for the data, compare it
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er,
                        input string nm);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!s_axi_rvalid) begin
      @(posedge mclk);
    end
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    `CHK(nm, {er, ed}, {s_axi_rresp, s_axi_rdata})
  endtask

  // the three power switches as {iso, a, b}
  task automatic sw_chk(input logic [2:0] e);
    `CHK("switches", e, {main_isolation_switch, charge_switch_a, charge_switch_b})
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // hang guard, run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk);
    bad_count++;
    $display("BAD watchdog exp done got hang");
    give_verdict;
  end

  // main sequence
  initial begin
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {main_drop_cmp, main_rise_cmp, batt_drop_cmp, batt_below_main_cmp} = 4'h0;
    {s_axi_awaddr, s_axi_wstrb, s_axi_araddr, s_axi_wdata} = 44'h0;
    repeat (6) @(posedge mclk);
    sw_chk(3'b001);
    nrst <= 1'b1;
    rd_chk(ADDR_CONFIG, 32'h1, RESP_OKAY, "config_reset");
    rd_chk(ADDR_STATUS, 32'h20, RESP_OKAY, "status_reset");
    rd_chk(4'h8, 32'h0, RESP_SLVERR, "unmapped_rd");
    wr_chk(4'hC, 32'h0, RESP_SLVERR, "unmapped_wr");
    // manual main-only selection
    wr_chk(ADDR_CONFIG, 32'h2, RESP_OKAY, "cfg_main");
    repeat (4) @(posedge mclk);
    sw_chk(3'b100);
    // all comparators active with automatic switching off
    main_drop_cmp <= 1'b1;
    main_rise_cmp <= 1'b1;
    batt_drop_cmp <= 1'b1;
    batt_below_main_cmp <= 1'b1;
    wr_chk(ADDR_CONFIG, 32'hA, RESP_OKAY, "cfg_chg_only");
    repeat (40) @(posedge mclk);
    sw_chk(3'b100);
    `CHK("host_if", 1'b1, host_if_enable)
    rd_chk(ADDR_STATUS, 32'h08, RESP_OKAY, "status_manual");
    // auto on, off time 2 ms, select ignored, drop held outside window
    wr_chk(ADDR_CONFIG, 32'h45, RESP_OKAY, "cfg_auto_off01");
    repeat (40) @(posedge mclk);
    sw_chk(3'b100);
    `CHK("host_if", 1'b1, host_if_enable)
    // no off window: the held drop moves to backup
    wr_chk(ADDR_CONFIG, 32'h05, RESP_OKAY, "cfg_auto_off00");
    repeat (10) @(posedge mclk);
    `CHK("host_if", 1'b0, host_if_enable)
    sw_chk(3'b001);
    // read and write attempt while host side is off
    seen = 1'b0;
    s_axi_araddr <= ADDR_CONFIG;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    repeat (30) begin
      @(posedge mclk);
      seen = seen | s_axi_arready | s_axi_rvalid | s_axi_awready | s_axi_wready | s_axi_bvalid;
    end
    `CHK("refused_bus", 1'b0, seen)
    // second reset in mid-run
    nrst <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    main_drop_cmp <= 1'b0;
    repeat (6) @(posedge mclk);
    sw_chk(3'b001);
    `CHK("host_if", 1'b1, host_if_enable)
    nrst <= 1'b1;
    rd_chk(ADDR_CONFIG, 32'h1, RESP_OKAY, "config_rereset");
    wr_chk(ADDR_STATUS, 32'h0, RESP_OKAY, "flag_clear");
    `CHK("low_flag", 1'b0, backup_low_flag)
    give_verdict;
  end
endmodule
